// ==== logic/abx_byte_alu.sv ====
// Byte adder, subtractor and logic unit with its status flags
`timescale 1ns/1ps
module abx_byte_alu #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  input wire logic sub,
  input wire abx_pkg::abx_fn_t fn,
  output logic [WIDTH-1:0] res,
  output abx_pkg::abx_flags_t flags
);
  logic [WIDTH:0] sum;
  logic a3, b3, r3, a7, b7, r7;

  // Half carry needs a bit three
  if (WIDTH < 4)
  begin : g_width_check
    $error("abx_byte_alu needs WIDTH of at least 4");
  end

  // Borrow appears as the top bit of the extended difference
  always_comb
  begin
    sum = sub ? ({1'b0, a} - {1'b0, b} - {{WIDTH{1'b0}}, cin})
              : ({1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin});
    case (fn)
      abx_pkg::ABX_FN_AND: res = a & b;
      abx_pkg::ABX_FN_OR: res = a | b;
      default: res = sum[WIDTH-1:0];
    endcase
    a3 = a[3];
    b3 = b[3];
    r3 = res[3];
    a7 = a[WIDTH-1];
    b7 = b[WIDTH-1];
    r7 = res[WIDTH-1];
    flags.c = (fn == abx_pkg::ABX_FN_ARITH) & sum[WIDTH];
    flags.h = sub ? ((~a3 & b3) | (b3 & r3) | (r3 & ~a3)) : ((a3 & b3) | (b3 & ~r3) | (~r3 & a3));
    // Logic results always clear overflow
    flags.v = (fn != abx_pkg::ABX_FN_ARITH) ? 1'b0
            : (sub ? ((a7 & ~b7 & ~r7) | (~a7 & b7 & r7)) : ((a7 & b7 & ~r7) | (~a7 & ~b7 & r7)));
    flags.n = r7;
    flags.z = (res == '0);
  end
endmodule // abx_byte_alu

// ==== logic/abx_exec_core.sv ====
// Execution core for byte, word and multiply arithmetic plus jumps, calls and skips
`timescale 1ns/1ps
module abx_exec_core (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic OP_VALID,
  input wire abx_pkg::abx_req_t OP_REQ,
  output logic OP_READY,
  output abx_pkg::abx_res_t RES,
  output logic [15:0] PC,
  output logic [7:0] SREG,
  output abx_pkg::abx_stack_t STACK
);
  abx_pkg::abx_state_t st;
  abx_pkg::abx_state_t next_st;
  abx_pkg::abx_commit_t cand;
  logic [2:0] cyc;
  logic accept;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  abx_pkg::abx_fn_t alu_fn;
  logic [7:0] alu_res;
  abx_pkg::abx_flags_t alu_flags;
  logic mul_sa;
  logic mul_sb;
  logic mul_frac;
  logic [15:0] mul_prod;
  logic mul_c;
  logic mul_z;
  logic [15:0] word_res;
  logic word_sub;
  logic word_v;
  logic word_c;
  logic [7:0] new_flags;
  logic [7:0] flag_mask;
  logic [15:0] pc_next;
  logic [15:0] rel_target;

  assign accept = OP_VALID && st.ready;
  assign pc_next = st.out.pc + abx_pkg::PC_STEP_ONE;
  assign rel_target = pc_next + {{4{OP_REQ.offset[11]}}, OP_REQ.offset};

  abx_byte_alu #(
    .WIDTH(8)
  ) u_alu (
    .a(OP_REQ.rd),
    .b(alu_b),
    .cin(alu_cin),
    .sub(alu_sub),
    .fn(alu_fn),
    .res(alu_res),
    .flags(alu_flags)
  );

  abx_mult #(
    .WIDTH(8)
  ) u_mult (
    .a(OP_REQ.rd),
    .b(OP_REQ.rr),
    .a_signed(mul_sa),
    .b_signed(mul_sb),
    .frac(mul_frac),
    .prod(mul_prod),
    .carry(mul_c),
    .zero(mul_z)
  );

  // Word pair arithmetic; only six bits of the constant take part
  always_comb
  begin
    word_sub = (OP_REQ.op == abx_pkg::ABX_OP_WORD_IMMEDIATE_DIFFERENCE);
    word_res = word_sub ? OP_REQ.pair - {10'h000, OP_REQ.imm[5:0] & abx_pkg::WORD_IMM_MASK}
                        : OP_REQ.pair + {10'h000, OP_REQ.imm[5:0] & abx_pkg::WORD_IMM_MASK};
    word_v = word_sub ? (OP_REQ.pair[15] & ~word_res[15]) : (~OP_REQ.pair[15] & word_res[15]);
    word_c = word_sub ? (word_res[15] & ~OP_REQ.pair[15]) : (~word_res[15] & OP_REQ.pair[15]);
  end

  // Operand steering for the byte unit and the multiplier
  always_comb
  begin
    alu_b = OP_REQ.rr;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    alu_fn = abx_pkg::ABX_FN_ARITH;
    mul_sa = 1'b0;
    mul_sb = 1'b0;
    mul_frac = 1'b0;
    case (OP_REQ.op)
      abx_pkg::ABX_OP_REG_CARRY_SUM: alu_cin = st.out.sreg[abx_pkg::SREG_C];
      abx_pkg::ABX_OP_REG_DIFF: alu_sub = 1'b1;
      abx_pkg::ABX_OP_CONSTANT_DIFFERENCE:
      begin
        alu_sub = 1'b1;
        alu_b = OP_REQ.imm;
      end
      abx_pkg::ABX_OP_CONSTANT_BORROW_DIFFERENCE:
      begin
        alu_sub = 1'b1;
        alu_b = OP_REQ.imm;
        alu_cin = st.out.sreg[abx_pkg::SREG_C];
      end
      abx_pkg::ABX_OP_REGISTER_BORROW_DIFFERENCE:
      begin
        alu_sub = 1'b1;
        alu_cin = st.out.sreg[abx_pkg::SREG_C];
      end
      abx_pkg::ABX_OP_REG_CONJ: alu_fn = abx_pkg::ABX_FN_AND;
      abx_pkg::ABX_OP_CONSTANT_CONJUNCTION:
      begin
        alu_fn = abx_pkg::ABX_FN_AND;
        alu_b = OP_REQ.imm;
      end
      abx_pkg::ABX_OP_REG_DISJ: alu_fn = abx_pkg::ABX_FN_OR;
      abx_pkg::ABX_OP_CONSTANT_DISJUNCTION:
      begin
        alu_fn = abx_pkg::ABX_FN_OR;
        alu_b = OP_REQ.imm;
      end
      abx_pkg::ABX_OP_ZERO_MINUS_CHECK:
      begin
        alu_fn = abx_pkg::ABX_FN_AND;
        alu_b = OP_REQ.rd;
      end
      abx_pkg::ABX_OP_MASK_BIT_CLEAR:
      begin
        alu_fn = abx_pkg::ABX_FN_AND;
        alu_b = abx_pkg::BYTE_ONES - OP_REQ.imm;
      end
      abx_pkg::ABX_OP_MASK_BIT_SET:
      begin
        alu_fn = abx_pkg::ABX_FN_OR;
        alu_b = OP_REQ.imm;
      end
      abx_pkg::ABX_OP_SIGNED_PRODUCT:
      begin
        mul_sa = 1'b1;
        mul_sb = 1'b1;
      end
      abx_pkg::ABX_OP_MIXED_SIGN_PRODUCT: mul_sa = 1'b1;
      abx_pkg::ABX_OP_FRAC_UNSIGNED_PRODUCT: mul_frac = 1'b1;
      abx_pkg::ABX_OP_FRAC_SIGNED_PRODUCT:
      begin
        mul_sa = 1'b1;
        mul_sb = 1'b1;
        mul_frac = 1'b1;
      end
      abx_pkg::ABX_OP_FRACTIONAL_MIXED_PRODUCT:
      begin
        mul_sa = 1'b1;
        mul_frac = 1'b1;
      end
      default: alu_b = OP_REQ.rr;
    endcase
  end

  // What each operation commits, and after how many cycles
  always_comb
  begin
    cand = '{sreg: st.out.sreg, pc: pc_next, res: '0, stack: '0};
    cyc = abx_pkg::CYC_BYTE;
    new_flags = {2'b00, alu_flags.h, 1'b0, alu_flags.v, alu_flags.n, alu_flags.z, alu_flags.c};
    flag_mask = 8'h00;
    case (OP_REQ.op)
      abx_pkg::ABX_OP_REG_SUM, abx_pkg::ABX_OP_REG_CARRY_SUM, abx_pkg::ABX_OP_REG_DIFF,
      abx_pkg::ABX_OP_CONSTANT_DIFFERENCE, abx_pkg::ABX_OP_CONSTANT_BORROW_DIFFERENCE,
      abx_pkg::ABX_OP_REGISTER_BORROW_DIFFERENCE:
      begin
        cand.res = '{write: 1'b1, wide: 1'b0, product: 1'b0, data: {abx_pkg::BYTE_ZERO, alu_res}};
        flag_mask = abx_pkg::MASK_ARITH;
      end
      abx_pkg::ABX_OP_REG_CONJ, abx_pkg::ABX_OP_CONSTANT_CONJUNCTION, abx_pkg::ABX_OP_REG_DISJ,
      abx_pkg::ABX_OP_CONSTANT_DISJUNCTION, abx_pkg::ABX_OP_ZERO_MINUS_CHECK,
      abx_pkg::ABX_OP_MASK_BIT_CLEAR, abx_pkg::ABX_OP_MASK_BIT_SET:
      begin
        cand.res = '{write: 1'b1, wide: 1'b0, product: 1'b0, data: {abx_pkg::BYTE_ZERO, alu_res}};
        flag_mask = abx_pkg::MASK_LOGIC;
      end
      abx_pkg::ABX_OP_WORD_IMMEDIATE_SUM, abx_pkg::ABX_OP_WORD_IMMEDIATE_DIFFERENCE:
      begin
        cyc = abx_pkg::CYC_WORD;
        cand.res = '{write: 1'b1, wide: 1'b1, product: 1'b0, data: word_res};
        new_flags = {3'b000, word_res[15] ^ word_v, word_v, word_res[15], (word_res == 16'h0000),
                     word_c};
        flag_mask = abx_pkg::MASK_WORD;
      end
      abx_pkg::ABX_OP_UNSIGNED_PRODUCT, abx_pkg::ABX_OP_SIGNED_PRODUCT,
      abx_pkg::ABX_OP_MIXED_SIGN_PRODUCT, abx_pkg::ABX_OP_FRAC_UNSIGNED_PRODUCT,
      abx_pkg::ABX_OP_FRAC_SIGNED_PRODUCT, abx_pkg::ABX_OP_FRACTIONAL_MIXED_PRODUCT:
      begin
        cyc = abx_pkg::CYC_MUL;
        cand.res = '{write: 1'b1, wide: 1'b1, product: 1'b1, data: mul_prod};
        new_flags = {6'h00, mul_z, mul_c};
        flag_mask = abx_pkg::MASK_MUL;
      end
      abx_pkg::ABX_OP_RELATIVE_JUMP:
      begin
        cyc = abx_pkg::CYC_REL_JUMP;
        cand.pc = rel_target;
      end
      abx_pkg::ABX_OP_POINTER_JUMP:
      begin
        cyc = abx_pkg::CYC_PTR_JUMP;
        cand.pc = OP_REQ.zptr;
      end
      abx_pkg::ABX_OP_DIRECT_JUMP:
      begin
        cyc = abx_pkg::CYC_DIR_JUMP;
        cand.pc = OP_REQ.target;
      end
      abx_pkg::ABX_OP_RELATIVE_SUBROUTINE_CALL:
      begin
        cyc = abx_pkg::CYC_REL_CALL;
        cand.pc = rel_target;
        cand.stack = '{push: 1'b1, pop: 1'b0, addr: pc_next};
      end
      abx_pkg::ABX_OP_POINTER_SUBROUTINE_CALL:
      begin
        cyc = abx_pkg::CYC_PTR_CALL;
        cand.pc = OP_REQ.zptr;
        cand.stack = '{push: 1'b1, pop: 1'b0, addr: pc_next};
      end
      // Direct call occupies two words, so it returns past both
      abx_pkg::ABX_OP_DIRECT_CALL:
      begin
        cyc = abx_pkg::CYC_DIR_CALL;
        cand.pc = OP_REQ.target;
        cand.stack = '{push: 1'b1, pop: 1'b0, addr: st.out.pc + abx_pkg::PC_STEP_TWO};
      end
      abx_pkg::ABX_OP_SUBROUTINE_RETURN, abx_pkg::ABX_OP_INTERRUPT_RETURN:
      begin
        cyc = abx_pkg::CYC_RETURN;
        cand.pc = OP_REQ.stack_top;
        cand.stack = '{push: 1'b0, pop: 1'b1, addr: OP_REQ.stack_top};
        new_flags = 8'h80;
        flag_mask = (OP_REQ.op == abx_pkg::ABX_OP_INTERRUPT_RETURN) ? 8'h80 : 8'h00;
      end
      abx_pkg::ABX_OP_EQUAL_COMPARE_SKIP:
        if (OP_REQ.rd == OP_REQ.rr)
        begin
          cyc = OP_REQ.next_long ? abx_pkg::CYC_SKIP_LONG : abx_pkg::CYC_SKIP_SHORT;
          cand.pc = st.out.pc + (OP_REQ.next_long ? abx_pkg::PC_STEP_THREE : abx_pkg::PC_STEP_TWO);
        end
      default: cyc = abx_pkg::CYC_BYTE;
    endcase
    cand.sreg = (st.out.sreg & ~flag_mask) | (new_flags & flag_mask);
  end

  // Sequencer: one-cycle work commits at acceptance, longer work waits out its count
  always_comb
  begin
    next_st = st;
    next_st.out.res.write = 1'b0;
    next_st.out.res.wide = 1'b0;
    next_st.out.res.product = 1'b0;
    next_st.out.stack.push = 1'b0;
    next_st.out.stack.pop = 1'b0;
    case (st.fsm)
      abx_pkg::ABX_ST_READY:
        if (accept)
        begin
          if (cyc == abx_pkg::CYC_BYTE)
          begin
            next_st.out = cand;
          end
          else
          begin
            next_st.pend = cand;
            next_st.cnt = cyc - 3'h1;
            next_st.ready = 1'b0;
            next_st.fsm = abx_pkg::ABX_ST_HOLD;
          end
        end
      abx_pkg::ABX_ST_HOLD:
        if (st.cnt == 3'h1)
        begin
          next_st.out = st.pend;
          next_st.ready = 1'b1;
          next_st.fsm = abx_pkg::ABX_ST_READY;
        end
        else
        begin
          next_st.cnt = st.cnt - 3'h1;
        end
      default:
      begin
        next_st.ready = 1'b1;
        next_st.fsm = abx_pkg::ABX_ST_READY;
      end
    endcase
  end

  // State register; reset clears the whole state, pending slot included, then loads ready, flags and PC
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      st <= '0;
      st.fsm <= abx_pkg::ABX_ST_READY;
      st.ready <= 1'b1;
      st.out.sreg <= abx_pkg::SREG_RESET;
      st.out.pc <= abx_pkg::PC_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign OP_READY = st.ready;
  assign RES = st.out.res;
  assign PC = st.out.pc;
  assign SREG = st.out.sreg;
  assign STACK = st.out.stack;

  // Operands captured for the checks below
  logic [7:0] a_rd_q;
  logic [7:0] a_rr_q;
  logic [7:0] a_imm_q;
  logic a_c_q;
  logic [15:0] a_z_q;
  always_ff @(posedge SYS_CLK)
  begin
    a_rd_q <= OP_REQ.rd;
    a_rr_q <= OP_REQ.rr;
    a_imm_q <= OP_REQ.imm;
    a_c_q <= SREG[abx_pkg::SREG_C];
    a_z_q <= OP_REQ.zptr;
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_carry_sum: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_REG_CARRY_SUM |=> RES.write && OP_READY
      && RES.data[7:0] == 8'(a_rd_q + a_rr_q + {7'h00, a_c_q}))
    else $error("carry sum result or timing wrong");
  a_word_sum_time: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_WORD_IMMEDIATE_SUM
      |=> !OP_READY && !RES.write ##1 OP_READY && RES.write && RES.wide)
    else $error("word sum not committed on second cycle");
  a_word_diff_sign: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_WORD_IMMEDIATE_DIFFERENCE |=> ##1 RES.wide
      && SREG[abx_pkg::SREG_S] == (SREG[abx_pkg::SREG_N] ^ SREG[abx_pkg::SREG_V]))
    else $error("word difference sign flag wrong");
  a_const_diff: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_CONSTANT_DIFFERENCE
      |=> RES.data[7:0] == 8'(a_rd_q - a_imm_q) && SREG[abx_pkg::SREG_C] == (a_imm_q > a_rd_q))
    else $error("constant difference wrong");
  a_const_borrow: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_CONSTANT_BORROW_DIFFERENCE
      |=> RES.data[7:0] == 8'(a_rd_q - a_imm_q - {7'h00, a_c_q}))
    else $error("constant borrow difference wrong");
  a_reg_borrow: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_REGISTER_BORROW_DIFFERENCE
      |=> RES.data[7:0] == 8'(a_rd_q - a_rr_q - {7'h00, a_c_q}))
    else $error("register borrow difference wrong");
  a_conj_flags: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_CONSTANT_CONJUNCTION
      |=> !SREG[abx_pkg::SREG_V] && SREG[abx_pkg::SREG_C] == a_c_q
      && RES.data[7:0] == (a_rd_q & a_imm_q))
    else $error("conjunction result or flags wrong");
  a_check_keeps: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_ZERO_MINUS_CHECK
      |=> RES.data[7:0] == a_rd_q && SREG[abx_pkg::SREG_N] == a_rd_q[7])
    else $error("zero-minus check changed value");
  a_mask_clear: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_MASK_BIT_CLEAR
      |=> RES.data[7:0] == (a_rd_q & ~a_imm_q))
    else $error("mask clear wrong");
  a_mixed_time: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_MIXED_SIGN_PRODUCT
      |=> !OP_READY ##1 OP_READY && RES.product && RES.wide)
    else $error("mixed product not on second cycle");
  a_jump_target: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_POINTER_JUMP
      |=> !OP_READY ##1 PC == $past(a_z_q) && SREG == $past(SREG, 2))
    else $error("pointer jump target or flags wrong");
  a_call_push: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_POINTER_SUBROUTINE_CALL
      |=> !OP_READY [*2] ##1 STACK.push && STACK.addr == 16'($past(PC, 3) + 16'h0001))
    else $error("pointer call push wrong");
  a_skip_equal: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_EQUAL_COMPARE_SKIP && OP_REQ.rd == OP_REQ.rr
      && !OP_REQ.next_long |=> !OP_READY ##1 PC == 16'($past(PC, 2) + 16'h0002))
    else $error("equal skip advance wrong");
  a_return_enable: assert property (
    accept && OP_REQ.op == abx_pkg::ABX_OP_INTERRUPT_RETURN
      |=> !OP_READY [*3] ##1 STACK.pop && SREG[abx_pkg::SREG_I])
    else $error("interrupt return did not pop or enable");
endmodule // abx_exec_core

// ==== logic/abx_mult.sv ====
// Multiplier with per-operand signedness and fractional shift
`timescale 1ns/1ps
module abx_mult #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic a_signed,
  input wire logic b_signed,
  input wire logic frac,
  output logic [2*WIDTH-1:0] prod,
  output logic carry,
  output logic zero
);
  logic signed [WIDTH:0] a_x;
  logic signed [WIDTH:0] b_x;
  logic signed [2*WIDTH+1:0] full;
  logic [2*WIDTH-1:0] raw;

  if (WIDTH < 2)
  begin : g_width_check
    $error("abx_mult needs WIDTH of at least 2");
  end

  // One extension bit lets one signed multiplier serve all three signedness mixes
  assign a_x = {a_signed & a[WIDTH-1], a};
  assign b_x = {b_signed & b[WIDTH-1], b};
  assign full = a_x * b_x;
  assign raw = full[2*WIDTH-1:0];
  // Carry is taken before the fractional shift drops the top bit
  assign prod = frac ? {raw[2*WIDTH-2:0], 1'b0} : raw;
  assign carry = raw[2*WIDTH-1];
  assign zero = (prod == '0);
endmodule // abx_mult

// ==== pkg/abx_pkg.sv ====
// Shared types and constants of the arithmetic, multiply and branch execution block
package abx_pkg;
  // Status register bit positions
  localparam int SREG_C = 0;
  localparam int SREG_Z = 1;
  localparam int SREG_N = 2;
  localparam int SREG_V = 3;
  localparam int SREG_S = 4;
  localparam int SREG_H = 5;
  localparam int SREG_T = 6;
  localparam int SREG_I = 7;
  // Reset values and fixed constants
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] WORD_IMM_MASK = 6'h3F;
  // Flags touched by each class of operation, as masks over the status register
  localparam logic [7:0] MASK_ARITH = 8'h2F;
  localparam logic [7:0] MASK_LOGIC = 8'h0E;
  localparam logic [7:0] MASK_WORD = 8'h1F;
  localparam logic [7:0] MASK_MUL = 8'h03;
  // Cycle counts per operation class
  localparam logic [2:0] CYC_BYTE = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
  localparam logic [2:0] CYC_DIR_JUMP = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_PTR_CALL = 3'h3;
  localparam logic [2:0] CYC_DIR_CALL = 3'h4;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
  localparam logic [2:0] CYC_SKIP_LONG = 3'h3;
  // Program counter advances in words
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;

  typedef enum logic [4:0] {
    ABX_OP_NONE, ABX_OP_REG_SUM, ABX_OP_REG_CARRY_SUM, ABX_OP_REG_DIFF,
    ABX_OP_CONSTANT_DIFFERENCE, ABX_OP_CONSTANT_BORROW_DIFFERENCE,
    ABX_OP_REGISTER_BORROW_DIFFERENCE, ABX_OP_REG_CONJ, ABX_OP_CONSTANT_CONJUNCTION,
    ABX_OP_REG_DISJ, ABX_OP_CONSTANT_DISJUNCTION, ABX_OP_ZERO_MINUS_CHECK,
    ABX_OP_MASK_BIT_CLEAR, ABX_OP_MASK_BIT_SET, ABX_OP_WORD_IMMEDIATE_SUM,
    ABX_OP_WORD_IMMEDIATE_DIFFERENCE, ABX_OP_UNSIGNED_PRODUCT, ABX_OP_SIGNED_PRODUCT,
    ABX_OP_MIXED_SIGN_PRODUCT, ABX_OP_FRAC_UNSIGNED_PRODUCT, ABX_OP_FRAC_SIGNED_PRODUCT,
    ABX_OP_FRACTIONAL_MIXED_PRODUCT, ABX_OP_RELATIVE_JUMP, ABX_OP_POINTER_JUMP,
    ABX_OP_DIRECT_JUMP, ABX_OP_RELATIVE_SUBROUTINE_CALL, ABX_OP_POINTER_SUBROUTINE_CALL,
    ABX_OP_DIRECT_CALL, ABX_OP_SUBROUTINE_RETURN, ABX_OP_INTERRUPT_RETURN,
    ABX_OP_EQUAL_COMPARE_SKIP
  } abx_op_t;

  typedef enum logic [1:0] {ABX_FN_ARITH = 2'h0, ABX_FN_AND = 2'h1, ABX_FN_OR = 2'h2} abx_fn_t;
  typedef enum logic [1:0] {ABX_ST_READY = 2'h0, ABX_ST_HOLD = 2'h1} abx_fsm_t;

  typedef struct packed {
    abx_op_t op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [7:0] imm;
    logic [15:0] pair;
    logic [15:0] zptr;
    logic [11:0] offset;
    logic [15:0] target;
    logic [15:0] stack_top;
    logic next_long;
  } abx_req_t;

  typedef struct packed {logic h; logic v; logic n; logic z; logic c;} abx_flags_t;
  typedef struct packed {logic write; logic wide; logic product; logic [15:0] data;} abx_res_t;
  typedef struct packed {logic push; logic pop; logic [15:0] addr;} abx_stack_t;
  typedef struct packed {logic [7:0] sreg; logic [15:0] pc; abx_res_t res; abx_stack_t stack;} abx_commit_t;
  typedef struct packed {
    abx_fsm_t fsm;
    logic [2:0] cnt;
    logic ready;
    abx_commit_t pend;
    abx_commit_t out;
  } abx_state_t;
endpackage

// ==== test/abx_decoder_model.sv ====
// Decoder and register file stand-in that offers one request at a time
`timescale 1ns/1ps
module abx_decoder_model (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output abx_pkg::abx_req_t req
);
  // Idle until the bench asks for a request
  initial
  begin
    valid = 1'h0;
    req = '0;
  end
  // Request held until an edge that samples ready high
  task automatic send(input abx_pkg::abx_req_t r);
    @(posedge clk);
    valid <= 1'h1;
    req <= r;
    do @(posedge clk); while (ready !== 1'h1);
    valid <= 1'h0;
    req <= ~r; // Released operands must not look valid
  endtask
endmodule // abx_decoder_model

// ==== test/abx_exec_core_tb.sv ====
// Self-checking bench of the execution core
`timescale 1ns/1ps
module abx_exec_core_tb;
  logic clk;
  logic rst_n;
  logic op_valid;
  logic op_ready;
  logic [15:0] pc;
  logic [7:0] sreg;
  abx_pkg::abx_req_t op_req;
  abx_pkg::abx_req_t q;
  abx_pkg::abx_res_t res;
  abx_pkg::abx_stack_t stack;
  int err_count = 0;
  int num_checks = 0;
  abx_exec_core u_abx_exec_core (.SYS_CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid),
    .OP_REQ(op_req), .OP_READY(op_ready), .RES(res), .PC(pc), .SREG(sreg), .STACK(stack));
  abx_decoder_model u_abx_decoder_model (.clk(clk), .ready(op_ready), .valid(op_valid),
    .req(op_req));
  // Free-running core clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic abx_pkg::abx_req_t mk(abx_pkg::abx_op_t op, logic [7:0] rd, rr, imm);
    mk = '0;
    mk.op = op;
    mk.rd = rd;
    mk.rr = rr;
    mk.imm = imm;
  endfunction
  // Issue q, count cycles to commit, then judge count, pc, flags and result
  task automatic go(input int n, input logic [15:0] epc, dat, input logic [7:0] sr);
    int c;
    u_abx_decoder_model.send(q);
    #1;
    c = 1;
    while (op_ready !== 1'h1 && c < 9)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    chk(16'(c), 16'(n));
    chk(pc, epc);
    chk({8'h00, sreg}, {8'h00, sr});
    if (dat !== 16'hFFFF || res.write === 1'h1) chk(res.data, dat);
  endtask
  task automatic t_byte;
    q = mk(abx_pkg::ABX_OP_REG_SUM, 8'h0F, 8'h01, 8'h00);
    go(1, 16'h0001, 16'h0010, 8'h20);
    q = mk(abx_pkg::ABX_OP_CONSTANT_DIFFERENCE, 8'h00, 8'h00, 8'h01);
    go(1, 16'h0002, 16'h00FF, 8'h25);
    q = mk(abx_pkg::ABX_OP_CONSTANT_CONJUNCTION, 8'h0F, 8'h00, 8'hF0);
    go(1, 16'h0003, 16'h0000, 8'h23);
    q = mk(abx_pkg::ABX_OP_REGISTER_BORROW_DIFFERENCE, 8'h05, 8'h02, 8'h00);
    go(1, 16'h0004, 16'h0002, 8'h00);
    $display("byte test done");
  endtask
  task automatic t_word;
    q = mk(abx_pkg::ABX_OP_WORD_IMMEDIATE_SUM, 8'h00, 8'h00, 8'h01);
    q.pair = 16'h00FF;
    go(2, 16'h0005, 16'h0100, 8'h00);
    q = mk(abx_pkg::ABX_OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 8'h00, 8'h01);
    go(2, 16'h0006, 16'hFFFF, 8'h15);
    $display("word test done");
  endtask
  task automatic t_product;
    q = mk(abx_pkg::ABX_OP_FRACTIONAL_MIXED_PRODUCT, 8'h40, 8'h02, 8'h00);
    go(2, 16'h0007, 16'h0100, 8'h14);
    chk({15'h0, res.product}, 16'h0001);
    q = mk(abx_pkg::ABX_OP_MIXED_SIGN_PRODUCT, 8'hFF, 8'h02, 8'h00);
    go(2, 16'h0008, 16'hFFFE, 8'h15);
    $display("product test done");
  endtask
  task automatic t_flow;
    q = mk(abx_pkg::ABX_OP_POINTER_SUBROUTINE_CALL, 8'h00, 8'h00, 8'h00);
    q.zptr = 16'h1234;
    go(3, 16'h1234, 16'hFFFF, 8'h15);
    chk({15'h0, stack.push}, 16'h0001);
    chk(stack.addr, 16'h0009);
    q = mk(abx_pkg::ABX_OP_INTERRUPT_RETURN, 8'h00, 8'h00, 8'h00);
    q.stack_top = 16'h0009;
    go(4, 16'h0009, 16'hFFFF, 8'h95);
    chk({15'h0, stack.pop}, 16'h0001);
    q = mk(abx_pkg::ABX_OP_EQUAL_COMPARE_SKIP, 8'h33, 8'h33, 8'h00);
    q.next_long = 1'h1;
    go(3, 16'h000C, 16'hFFFF, 8'h95);
    q.rr = 8'h34;
    go(1, 16'h000D, 16'hFFFF, 8'h95);
    q = mk(abx_pkg::ABX_OP_RELATIVE_JUMP, 8'h00, 8'h00, 8'h00);
    q.offset = 12'hFFE;
    go(2, 16'h000C, 16'hFFFF, 8'h95);
    $display("flow test done");
  endtask
  // Build a plain request and run it through go
  task automatic gm(input abx_pkg::abx_op_t op, input logic [7:0] rd, rr, imm, input int n,
    input logic [15:0] epc, dat, input logic [7:0] sr);
    q = mk(op, rd, rr, imm);
    go(n, epc, dat, sr);
  endtask
  // Mid-run reset: one low edge clears PC, flags and pulses
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk({op_ready, sreg, pc[6:0]}, 16'h8000);
    chk({pc[15:7], res.write, stack.push, stack.pop, 4'h0}, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_logic;
    gm(abx_pkg::ABX_OP_REG_DIFF, 8'h10, 8'h20, 8'h00, 1, 16'h0001, 16'h00F0, 8'h05);
    gm(abx_pkg::ABX_OP_REG_CARRY_SUM, 8'hFF, 8'h00, 8'h00, 1, 16'h0002, 16'h0000, 8'h23);
    gm(abx_pkg::ABX_OP_CONSTANT_BORROW_DIFFERENCE, 8'h10, 8'h00, 8'h0F,
      1, 16'h0003, 16'h0000, 8'h22);
    gm(abx_pkg::ABX_OP_REG_CONJ, 8'hC3, 8'h81, 8'h00, 1, 16'h0004, 16'h0081, 8'h24);
    gm(abx_pkg::ABX_OP_REG_DISJ, 8'h00, 8'h00, 8'hFF, 1, 16'h0005, 16'h0000, 8'h22);
    gm(abx_pkg::ABX_OP_CONSTANT_DISJUNCTION, 8'h12, 8'h00, 8'h80,
      1, 16'h0006, 16'h0092, 8'h24);
    gm(abx_pkg::ABX_OP_ZERO_MINUS_CHECK, 8'h7E, 8'h00, 8'h00, 1, 16'h0007, 16'h007E, 8'h20);
    gm(abx_pkg::ABX_OP_MASK_BIT_CLEAR, 8'hFF, 8'h00, 8'h0F, 1, 16'h0008, 16'h00F0, 8'h24);
    gm(abx_pkg::ABX_OP_MASK_BIT_SET, 8'h01, 8'h00, 8'h40, 1, 16'h0009, 16'h0041, 8'h20);
    gm(abx_pkg::ABX_OP_NONE, 8'h00, 8'h00, 8'h00, 1, 16'h000A, 16'hFFFF, 8'h20);
    $display("logic test done");
  endtask
  task automatic t_mul;
    gm(abx_pkg::ABX_OP_UNSIGNED_PRODUCT, 8'hFF, 8'hFF, 8'h00, 2, 16'h000B, 16'hFE01, 8'h21);
    gm(abx_pkg::ABX_OP_SIGNED_PRODUCT, 8'h00, 8'hFF, 8'h00, 2, 16'h000C, 16'h0000, 8'h22);
    gm(abx_pkg::ABX_OP_FRAC_UNSIGNED_PRODUCT, 8'hFF, 8'hFF, 8'h00,
      2, 16'h000D, 16'hFC02, 8'h21);
    gm(abx_pkg::ABX_OP_FRAC_SIGNED_PRODUCT, 8'h80, 8'h80, 8'h00,
      2, 16'h000E, 16'h8000, 8'h20);
    $display("mul test done");
  endtask
  task automatic t_branch;
    q = mk(abx_pkg::ABX_OP_POINTER_JUMP, 8'h00, 8'h00, 8'h00);
    q.zptr = 16'h0100;
    go(2, 16'h0100, 16'hFFFF, 8'h20);
    q = mk(abx_pkg::ABX_OP_EQUAL_COMPARE_SKIP, 8'h5A, 8'h5A, 8'h00);
    go(2, 16'h0102, 16'hFFFF, 8'h20);
    q = mk(abx_pkg::ABX_OP_RELATIVE_SUBROUTINE_CALL, 8'h00, 8'h00, 8'h00);
    q.offset = 12'h010;
    go(3, 16'h0113, 16'hFFFF, 8'h20);
    chk(stack.addr, 16'h0103);
    q = mk(abx_pkg::ABX_OP_DIRECT_JUMP, 8'h00, 8'h00, 8'h00);
    q.target = 16'h0200;
    go(3, 16'h0200, 16'hFFFF, 8'h20);
    q = mk(abx_pkg::ABX_OP_DIRECT_CALL, 8'h00, 8'h00, 8'h00);
    q.target = 16'h0300;
    go(4, 16'h0300, 16'hFFFF, 8'h20);
    chk({15'h0, stack.push}, 16'h0001);
    chk(stack.addr, 16'h0202);
    q = mk(abx_pkg::ABX_OP_SUBROUTINE_RETURN, 8'h00, 8'h00, 8'h00);
    q.stack_top = 16'h0202;
    go(4, 16'h0202, 16'hFFFF, 8'h20);
    chk({15'h0, stack.pop}, 16'h0001);
    $display("branch test done");
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard at 2000 cycles, far beyond the roughly 100 cycles the tests need
  initial
  begin
    #20000;
    err_count++;
    print_verdict();
  end
  // Reset for two cycles, then the scenarios
  initial
  begin
    rst_n = 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk({op_ready, sreg, pc[6:0]}, 16'h8000);
    t_byte();
    t_word();
    t_product();
    t_flow();
    t_reset();
    t_logic();
    t_mul();
    t_branch();
    print_verdict();
  end
endmodule // abx_exec_core_tb
